// ===== aafv_defs.vh
// register offsets, field positions, reset values and timing counts of the format/volume/fault bank
`ifndef AAFV_DEFS_VH
`define AAFV_DEFS_VH
// ****************************************
// register offsets
// ****************************************
`define AAFV_OFS_FMT_RATE     8'h02
`define AAFV_OFS_CLK_OPT      8'h03
`define AAFV_OFS_CH_MAP       8'h04
`define AAFV_OFS_ATTEN        8'h05
`define AAFV_OFS_GAIN_MUTE    8'h06
`define AAFV_OFS_FAULT        8'h07
// ****************************************
// reset values
// ****************************************
`define AAFV_RST_FMT_RATE     8'h02
`define AAFV_RST_CLK_OPT      8'h00
`define AAFV_RST_CH_MAP       8'h00
`define AAFV_RST_ATTEN        8'h40
`define AAFV_RST_GAIN_MUTE    8'h11
`define AAFV_RST_FAULT        8'h0C
// ****************************************
// field positions
// ****************************************
`define AAFV_FMT_SAMPLE_MSB   6
`define AAFV_FMT_SAMPLE_LSB   5
`define AAFV_FMT_FRAME_MSB    4
`define AAFV_FMT_FRAME_LSB    2
`define AAFV_FMT_RATE_MSB     1
`define AAFV_FMT_RATE_LSB     0
`define AAFV_CLK_INT_BIT      7
`define AAFV_CLK_MODE_BIT     6
`define AAFV_CLK_INV_BIT      5
`define AAFV_CLK_ORDER_BIT    4
`define AAFV_CLK_SLOT_MSB     3
`define AAFV_CLK_SLOT_LSB     2
`define AAFV_CLK_EDGE_BIT     1
`define AAFV_CH_MAP_MSB       3
`define AAFV_CH_MAP_LSB       0
`define AAFV_GM_ZMUTE_BIT     7
`define AAFV_GM_GAIN_MSB      5
`define AAFV_GM_GAIN_LSB      4
`define AAFV_GM_MUTE_BIT      0
`define AAFV_FLT_OC_BIT       6
`define AAFV_FLT_OT_BIT       5
`define AAFV_FLT_MAN_BIT      4
`define AAFV_FLT_LIMIT_MSB    3
`define AAFV_FLT_LIMIT_LSB    2
`define AAFV_FLT_POL_MSB      1
`define AAFV_FLT_POL_LSB      0
// ****************************************
// codes and timing counts
// ****************************************
`define AAFV_POLICY_NONE      2'b11
`define AAFV_ATTEN_MUTE       8'hFF
`define AAFV_ZERO_RUN         2048
`define AAFV_RATE_DEFAULT     2'b10
`endif

// ===== aafv_regfile.v
// six byte-wide configuration registers with write masks and reset values
`include "aafv_defs.vh"
`default_nettype none
module aafv_regfile #(
	parameter NREG = 6
) (
	// clock and reset
	input  wire             mclk_in,
	input  wire             rst_b_in,
	// write port
	input  wire             wr_in,
	input  wire [2:0]       idx_in,
	input  wire [7:0]       wdata_in,
	// read port, registered
	input  wire [2:0]       ridx_in,
	output reg  [7:0]       rdata_out,
	// flat register image
	output wire [8*NREG-1:0] image_out
);
	// ****************************************
	// storage
	// ****************************************
	reg [7:0] mem_q [0:NREG-1];

	// reset value and writable-bit mask per index
	function [15:0] rst_mask;
		input [2:0] i;
		begin
			case (i)
				3'h0: rst_mask = {`AAFV_RST_FMT_RATE, 8'h7F};
				3'h1: rst_mask = {`AAFV_RST_CLK_OPT, 8'hFE};
				3'h2: rst_mask = {`AAFV_RST_CH_MAP, 8'h0F};
				3'h3: rst_mask = {`AAFV_RST_ATTEN, 8'hFF};
				3'h4: rst_mask = {`AAFV_RST_GAIN_MUTE, 8'hB1};
				3'h5: rst_mask = {`AAFV_RST_FAULT, 8'h0F}; // status and trigger bits never stored
				default: rst_mask = 16'h0000;
			endcase
		end
	endfunction

	genvar g;
	generate
		for (g = 0; g < NREG; g = g + 1) begin : g_reg
			localparam [2:0] GI = g;
			localparam [15:0] RM = rst_mask(GI);
			// reserved bits stay zero because the mask keeps them out
			always @(posedge mclk_in or negedge rst_b_in) begin
				if (!rst_b_in) begin
					mem_q[g] <= RM[15:8];
				end else if (wr_in && idx_in == GI) begin
					mem_q[g] <= wdata_in & RM[7:0];
				end
			end
			assign image_out[8*g+7:8*g] = mem_q[g];
		end
	endgenerate

	// read data from a register
	always @(posedge mclk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			rdata_out <= 8'h00;
		end else if (ridx_in < NREG) begin
			rdata_out <= mem_q[ridx_in];
		end else begin
			rdata_out <= 8'h00;
		end
	end
endmodule
`default_nettype wire

// ===== aafv_top.v
// format, volume, gain and fault register bank with automute and recovery sequencing
// Overview of operation
// R1: sample format field bits 6:5 picks I2S, left, right 24 or right 16.
// R2: frame structure field bits 4:2 picks stereo, TDM2/4/8/16 or mono PCM.
// R3: internal bit clock bit set means derive bit clock internally, ignore the pin.
// R4: TDM frame clock mode picks 50% or pulse; invert bit flips its sense.
// R5: bit order 0 means msb first, 1 means lsb first.
// R6: slot width field gives 32, 24 or 16 bit clocks per slot.
// R7: edge select 0 means rising edge, 1 means falling edge.
// R8: channel map field picks input slot 0 to 15 for the output.
// R9: software maps only to slots the chosen frame structure provides.
// R10: attenuation code 0x00 is +24 dB, 0.375 dB steps, 0xFF mutes.
// R11: automute, active when control bit is 0, mutes after 2048 zero samples.
// R12: modulator gain field bits 5:4 picks 2, 3.6, 4.2 or 5 V setting.
// R13: master mute soft-mutes both channels and resets set.
// R14: writing 1 to manual recovery triggers one attempt only when policy is 11.
// R15: retry limit allows 1, 3, 7 or unlimited automatic attempts.
// R16: policy field enables auto recovery for both, thermal, overcurrent or none.
// R17: with auto rate detect off, the rate band comes from the rate field.
// R18: fault flags read live condition; writes to them do nothing.
// R19: software avoids reserved codes in format, rate and slot width fields.
`include "aafv_defs.vh"
`default_nettype none
module aafv_top #(
	// zero samples in a row before automute; shortened in simulation
	parameter ZERO_RUN = `AAFV_ZERO_RUN
) (
	// clock and reset
	input  wire       mclk_in,
	input  wire       rst_b_in,
	// register access from the control port
	input  wire       reg_wr_in,
	input  wire       reg_rd_in,
	input  wire [7:0] reg_addr_in,
	input  wire [7:0] reg_wdata_in,
	output reg  [7:0] reg_rdata_out,
	output reg        reg_ack_out,
	// neighbouring control from the system register
	input  wire       auto_rate_detect_in,
	input  wire [1:0] detected_rate_in,
	// audio sample flow and fault pins
	input  wire       sample_strobe_in,
	input  wire       sample_zero_in,
	input  wire       overcurrent_pin_in,
	input  wire       thermal_pin_in,
	// datapath configuration
	output reg  [1:0] sample_format_sel_out,
	output reg  [2:0] frame_structure_sel_out,
	output reg  [1:0] rate_band_sel_out,
	output reg        internal_bit_clock_en_out,
	output reg        frame_clock_pulse_out,
	output reg        frame_clock_invert_out,
	output reg        bit_order_sel_out,
	output reg  [5:0] slot_bits_out,
	output reg        falling_edge_sel_out,
	output reg  [3:0] channel_map_field_out,
	output reg  [7:0] attenuation_code_out,
	output reg  [1:0] modulator_gain_sel_out,
	output reg        output_mute_out,
	// recovery
	output reg        recovery_pulse_out
);
	// ****************************************
	// input synchronisers
	// ****************************************
	reg  [1:0] oc_meta_q;
	reg  [1:0] ot_meta_q;
	// fault pins come from the power stage unclocked; two flops before any use
	always @(posedge mclk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			oc_meta_q <= 2'b00;
			ot_meta_q <= 2'b00;
		end else begin
			oc_meta_q <= {oc_meta_q[0], overcurrent_pin_in};
			ot_meta_q <= {ot_meta_q[0], thermal_pin_in};
		end
	end
	wire overcurrent_flag   = oc_meta_q[1];
	wire thermal_fault_flag = ot_meta_q[1];

	// ****************************************
	// address decode and register file
	// ****************************************
	// offset to register index; bit 3 marks a hit in this bank
	function [3:0] decode;
		input [7:0] a;
		begin
			if (a >= `AAFV_OFS_FMT_RATE && a <= `AAFV_OFS_FAULT) begin
				decode = {1'b1, a[2:0] - 3'd2};
			end else begin
				decode = 4'h0;
			end
		end
	endfunction

	wire [3:0]  wdec = decode(reg_addr_in);
	wire [47:0] image;
	wire        wr_hit = reg_wr_in & wdec[3];

	// write mask inside the register file keeps reserved and read-only bits at zero
	aafv_regfile #(
		.NREG(6)
	) u_regfile (
		.mclk_in   (mclk_in),
		.rst_b_in  (rst_b_in),
		.wr_in     (wr_hit),
		.idx_in    (wdec[2:0]),
		.wdata_in  (reg_wdata_in),
		.ridx_in   (wdec[3] ? wdec[2:0] : 3'd7),
		.rdata_out (),
		.image_out (image)
	);

	wire [7:0] fmt_r   = image[7:0];
	wire [7:0] clk_r   = image[15:8];
	wire [7:0] chm_r   = image[23:16];
	wire [7:0] att_r   = image[31:24];
	wire [7:0] gm_r    = image[39:32];
	wire [7:0] flt_r   = image[47:40];
	// recovery fields used by the sequencer below
	wire [1:0] policy  = flt_r[`AAFV_FLT_POL_MSB:`AAFV_FLT_POL_LSB];
	wire [1:0] limit   = flt_r[`AAFV_FLT_LIMIT_MSB:`AAFV_FLT_LIMIT_LSB];

	// read answer registered at the strobe edge, so it stands the cycle ack does
	// unmapped offsets answer zero; the fault register shows the live flags
	always @(posedge mclk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			reg_rdata_out <= 8'h00;
		end else if (!wdec[3]) begin
			reg_rdata_out <= 8'h00;
		end else begin
			reg_rdata_out <= image[8*wdec[2:0] +: 8];
			// flags overlaid live, trigger bit reads zero [R18] [R14]
			if (reg_addr_in == `AAFV_OFS_FAULT) begin
				reg_rdata_out[`AAFV_FLT_OC_BIT] <= overcurrent_flag;
				reg_rdata_out[`AAFV_FLT_OT_BIT] <= thermal_fault_flag;
			end
		end
	end
	// ack pulses for writes and reads alike
	// unmapped offsets still acked so the control port never stalls
	always @(posedge mclk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			reg_ack_out <= 1'b0;
		end else begin
			reg_ack_out <= reg_wr_in | reg_rd_in;
		end
	end

	// ****************************************
	// format and clock decode
	// ****************************************
	function [5:0] slot_len;
		input [1:0] code;
		begin
			case (code)
				2'b00: slot_len = 6'd32;
				2'b01: slot_len = 6'd24;
				2'b10: slot_len = 6'd16;
				default: slot_len = 6'd32; // reserved code, kept harmless
			endcase
		end
	endfunction

	// every field lands in its own output flop, two cycles after the write strobe
	always @(posedge mclk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			sample_format_sel_out     <= 2'b00;
			frame_structure_sel_out   <= 3'b000;
			rate_band_sel_out         <= `AAFV_RATE_DEFAULT;
			internal_bit_clock_en_out <= 1'b0;
			frame_clock_pulse_out     <= 1'b0;
			frame_clock_invert_out    <= 1'b0;
			bit_order_sel_out         <= 1'b0;
			slot_bits_out             <= 6'd32;
			falling_edge_sel_out      <= 1'b0;
			channel_map_field_out     <= 4'h0;
			modulator_gain_sel_out    <= 2'b01;
		end else begin
			sample_format_sel_out     <= fmt_r[`AAFV_FMT_SAMPLE_MSB:`AAFV_FMT_SAMPLE_LSB]; // [R1]
			frame_structure_sel_out   <= fmt_r[`AAFV_FMT_FRAME_MSB:`AAFV_FMT_FRAME_LSB];   // [R2]
			rate_band_sel_out         <= auto_rate_detect_in ? detected_rate_in
				: fmt_r[`AAFV_FMT_RATE_MSB:`AAFV_FMT_RATE_LSB];                             // [R17]
			internal_bit_clock_en_out <= clk_r[`AAFV_CLK_INT_BIT];                          // [R3]
			// pulse mode only means something in TDM frames
			frame_clock_pulse_out     <= clk_r[`AAFV_CLK_MODE_BIT]
				& (fmt_r[`AAFV_FMT_FRAME_MSB:`AAFV_FMT_FRAME_LSB] != 3'b000);               // [R4]
			frame_clock_invert_out    <= clk_r[`AAFV_CLK_INV_BIT];                          // [R4]
			bit_order_sel_out         <= clk_r[`AAFV_CLK_ORDER_BIT];                        // [R5]
			slot_bits_out             <= slot_len(clk_r[`AAFV_CLK_SLOT_MSB:`AAFV_CLK_SLOT_LSB]); // [R6]
			falling_edge_sel_out      <= clk_r[`AAFV_CLK_EDGE_BIT];                         // [R7]
			// no range clamp: software keeps the slot inside the frame [R9]
			channel_map_field_out     <= chm_r[`AAFV_CH_MAP_MSB:`AAFV_CH_MAP_LSB];          // [R8]
			modulator_gain_sel_out    <= gm_r[`AAFV_GM_GAIN_MSB:`AAFV_GM_GAIN_LSB];         // [R12]
		end
	end

	// ****************************************
	// automute and volume
	// ****************************************
	reg [11:0] zero_run_q;
	reg        zero_muted_q;
	wire       zero_run_ctl = gm_r[`AAFV_GM_ZMUTE_BIT]; // 0 means automute active
	// counter saturates; any nonzero sample ends the run at once
	// limitation: counts strobes, so a stalled sample stream never mutes
	always @(posedge mclk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			zero_run_q   <= 12'h000;
			zero_muted_q <= 1'b0;
		end else if (zero_run_ctl) begin
			zero_run_q   <= 12'h000;
			zero_muted_q <= 1'b0;
		end else if (sample_strobe_in) begin
			if (!sample_zero_in) begin
				zero_run_q   <= 12'h000;
				zero_muted_q <= 1'b0;
			end else if (zero_run_q == ZERO_RUN[11:0] - 12'h001) begin
				zero_muted_q <= 1'b1; // [R11]
			end else begin
				zero_run_q <= zero_run_q + 12'h001;
			end
		end
	end

	// code passes to the gain stage; all ones also forces mute
	always @(posedge mclk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			attenuation_code_out <= `AAFV_RST_ATTEN;
			output_mute_out      <= 1'b1;
		end else begin
			attenuation_code_out <= att_r; // [R10]
			output_mute_out      <= gm_r[`AAFV_GM_MUTE_BIT] | zero_muted_q
				| (att_r == `AAFV_ATTEN_MUTE); // [R13] [R10] [R11]
		end
	end

	// ****************************************
	// fault recovery sequencing
	// ****************************************
	// recovery sequencer: a pulse, a one-cycle pause, then a recheck
	localparam ST_IDLE  = 2'd0;
	localparam ST_FAULT = 2'd1;
	localparam ST_DONE  = 2'd2;

	reg [1:0] state_q;
	reg [2:0] tries_q;
	wire      fault_any = overcurrent_flag | thermal_fault_flag;
	// automatic recovery allowed for every fault type present [R16]
	wire      auto_ok   = (!overcurrent_flag | ~policy[0]) & (!thermal_fault_flag | ~policy[1]);
	wire      man_req   = wr_hit && wdec[2:0] == 3'd5 && reg_wdata_in[`AAFV_FLT_MAN_BIT]
		&& policy == `AAFV_POLICY_NONE; // [R14]
	// attempts allowed per retry limit code; unlimited is handled apart
	function [2:0] retry_cap;
		input [1:0] code;
		begin
			case (code)
				2'b00: retry_cap = 3'd1;
				2'b01: retry_cap = 3'd3;
				2'b10: retry_cap = 3'd7;
				default: retry_cap = 3'd7; // unlimited, budget check bypassed
			endcase
		end
	endfunction

	// retry budget: 1, 3, 7 or unlimited
	wire      budget_ok = (limit == 2'b11) || (tries_q < retry_cap(limit)); // [R15]

	always @(posedge mclk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			state_q            <= ST_IDLE;
			tries_q            <= 3'd0;
			recovery_pulse_out <= 1'b0;
		end else begin
			recovery_pulse_out <= 1'b0;
			case (state_q)
				ST_IDLE: begin
					// budget refills only once every fault has cleared
					tries_q <= 3'd0;
					if (fault_any) begin
						state_q <= ST_FAULT;
					end
				end
				ST_FAULT: begin
					if (!fault_any) begin
						state_q <= ST_IDLE;
					end else if (man_req) begin
						// a manual request never spends the automatic budget
						recovery_pulse_out <= 1'b1; // [R14]
					end else if (policy != `AAFV_POLICY_NONE && auto_ok && budget_ok) begin
						recovery_pulse_out <= 1'b1; // [R15] [R16]
						tries_q            <= tries_q + 3'd1;
						state_q            <= ST_DONE;
					end
				end
				ST_DONE: begin
					// one cycle for the power stage to react before rechecking
					state_q <= ST_FAULT;
				end
				default: state_q <= ST_IDLE;
			endcase
		end
	end
endmodule
`default_nettype wire

// ===== aafv_monitor.sv
// checker on the register bank ports: field decode, mute and recovery pulse timing
`default_nettype none
module aafv_monitor (
	// clock and reset
	input  wire logic       mclk_in,
	input  wire logic       rst_b_in,
	// register port
	input  wire logic       reg_wr_in,
	input  wire logic [7:0] reg_addr_in,
	input  wire logic [7:0] reg_wdata_in,
	// decoded configuration
	input  wire logic [1:0] sample_format_sel_out,
	input  wire logic [2:0] frame_structure_sel_out,
	input  wire logic       internal_bit_clock_en_out,
	input  wire logic       bit_order_sel_out,
	input  wire logic [5:0] slot_bits_out,
	input  wire logic       falling_edge_sel_out,
	input  wire logic [3:0] channel_map_field_out,
	input  wire logic [7:0] attenuation_code_out,
	input  wire logic [1:0] modulator_gain_sel_out,
	input  wire logic       output_mute_out,
	input  wire logic       recovery_pulse_out
);
	timeunit 1ns;
	timeprecision 100ps;
	default clocking cb @(posedge mclk_in); endclocking
	default disable iff (!rst_b_in);
	// offset of the write in flight, zero when idle
	wire logic [7:0] wa = reg_wr_in ? reg_addr_in : 8'h00;
	property p_fmt;
		logic [7:0] v;
		(wa == 8'h02, v = reg_wdata_in) |-> ##2 {sample_format_sel_out, frame_structure_sel_out} == v[6:2];
	endproperty
	a_fmt: assert property (p_fmt) else $error("format fields not decoded");
	property p_clk;
		logic [7:0] v;
		(wa == 8'h03, v = reg_wdata_in) |-> ##2
			{internal_bit_clock_en_out, bit_order_sel_out, falling_edge_sel_out} == {v[7], v[4], v[1]};
	endproperty
	a_clk: assert property (p_clk) else $error("clock option bits not decoded");
	property p_slot;
		logic [1:0] c;
		(wa == 8'h03, c = reg_wdata_in[3:2]) |-> ##2 slot_bits_out == (c == 2'b01 ? 6'd24 : (c == 2'b10 ? 6'd16 : 6'd32));
	endproperty
	a_slot: assert property (p_slot) else $error("slot width wrong");
	property p_map;
		logic [7:0] v;
		(wa == 8'h04, v = reg_wdata_in) |-> ##2 channel_map_field_out == v[3:0];
	endproperty
	a_map: assert property (p_map) else $error("channel map wrong");
	property p_atten;
		logic [7:0] v;
		(wa == 8'h05, v = reg_wdata_in) |-> ##2 attenuation_code_out == v;
	endproperty
	a_atten: assert property (p_atten) else $error("attenuation code wrong");
	property p_gain;
		logic [7:0] v;
		(wa == 8'h06, v = reg_wdata_in) |-> ##2 modulator_gain_sel_out == v[5:4] && (!v[0] || output_mute_out);
	endproperty
	a_gain: assert property (p_gain) else $error("gain or master mute wrong");
	property p_ffmute;
		attenuation_code_out == 8'hFF && $past(attenuation_code_out) == 8'hFF |-> output_mute_out;
	endproperty
	a_ffmute: assert property (p_ffmute) else $error("full attenuation not muting");
	property p_pulse;
		recovery_pulse_out |=> !recovery_pulse_out;
	endproperty
	a_pulse: assert property (p_pulse) else $error("recovery pulse too long");
endmodule
bind aafv_top aafv_monitor u_mon (.mclk_in, .rst_b_in, .reg_wr_in, .reg_addr_in, .reg_wdata_in,
	.sample_format_sel_out, .frame_structure_sel_out, .internal_bit_clock_en_out, .bit_order_sel_out,
	.slot_bits_out, .falling_edge_sel_out, .channel_map_field_out, .attenuation_code_out,
	.modulator_gain_sel_out, .output_mute_out, .recovery_pulse_out);
`default_nettype wire

// ===== aafv_host.sv
// host controller model issuing single-byte register transfers
`default_nettype none
module aafv_host (
	// clock
	input  wire logic       mclk_in,
	// register port
	output var  logic       reg_wr_out,
	output var  logic       reg_rd_out,
	output var  logic [7:0] reg_addr_out,
	output var  logic [7:0] reg_wdata_out,
	input  wire logic [7:0] reg_rdata_in,
	input  wire logic       reg_ack_in
);
	timeunit 1ns;
	timeprecision 100ps;
	// idle bus at time zero
	initial begin
		reg_wr_out = 1'b0;
		reg_rd_out = 1'b0;
		reg_addr_out = 8'h00;
		reg_wdata_out = 8'h00;
	end
	// one strobe cycle; idle gap first so the host can be slow
	task automatic xfer(input logic w, input logic [7:0] a, input logic [7:0] d, input int gap,
		output logic [7:0] q, output logic k);
		repeat (gap) @(posedge mclk_in);
		@(posedge mclk_in);
		#2;
		reg_wr_out = w;
		reg_rd_out = !w;
		reg_addr_out = a;
		reg_wdata_out = d;
		@(posedge mclk_in);
		#2;
		reg_wr_out = 1'b0;
		reg_rd_out = 1'b0;
		k = reg_ack_in;
		q = reg_rdata_in;
		// released lines must not keep the old value
		reg_addr_out = ~a;
		reg_wdata_out = ~d;
	endtask
endmodule
`default_nettype wire

// ===== audio_amp_format_volume_fault_regs_tb.sv
// self-checking bench for the format, volume and fault register bank
`default_nettype none
`include "aafv_defs.vh"
module audio_amp_format_volume_fault_regs_tb;
	timeunit 1ns;
	timeprecision 100ps;
	localparam int ZR = 8;
	localparam logic [7:0] MSK [2:7] = '{8'h7F, 8'hFE, 8'h0F, 8'hFF, 8'hB1, 8'h0F};
	logic        mclk_in, rst_b_in, ard, s_stb, s_zero, oc, ot, am;
	logic        reg_wr, reg_rd, reg_ack, pls, mute, intc, pul, inv, ord, edg;
	logic [1:0]  det, fmt, rate, gain;
	logic [2:0]  frm;
	logic [3:0]  map;
	logic [5:0]  slot;
	logic [7:0]  addr, wdat, rdat, att;
	logic [7:0]  mdl [2:7];
	logic [31:0] seed;
	int          n_fail, total_checks, npl, cyc;
	aafv_top #(.ZERO_RUN(ZR)) u_aafv_top (.mclk_in(mclk_in), .rst_b_in(rst_b_in), .reg_wr_in(reg_wr),
		.reg_rd_in(reg_rd), .reg_addr_in(addr), .reg_wdata_in(wdat), .reg_rdata_out(rdat), .reg_ack_out(reg_ack),
		.auto_rate_detect_in(ard), .detected_rate_in(det), .sample_strobe_in(s_stb), .sample_zero_in(s_zero),
		.overcurrent_pin_in(oc), .thermal_pin_in(ot), .sample_format_sel_out(fmt), .frame_structure_sel_out(frm),
		.rate_band_sel_out(rate), .internal_bit_clock_en_out(intc), .frame_clock_pulse_out(pul),
		.frame_clock_invert_out(inv), .bit_order_sel_out(ord), .slot_bits_out(slot), .falling_edge_sel_out(edg),
		.channel_map_field_out(map), .attenuation_code_out(att), .modulator_gain_sel_out(gain),
		.output_mute_out(mute), .recovery_pulse_out(pls));
	aafv_host u_aafv_host (.mclk_in(mclk_in), .reg_wr_out(reg_wr), .reg_rd_out(reg_rd), .reg_addr_out(addr),
		.reg_wdata_out(wdat), .reg_rdata_in(rdat), .reg_ack_in(reg_ack));
	function automatic logic [31:0] nx(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction
	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] s);
		total_checks++;
		if (s !== e) begin
			n_fail++;
			$display("[FAIL] %s expected %0h seen %0h", nm, e, s);
		end
	endtask
	// transfer plus model update; reads compared with stored bits and live fault pins
	task automatic xf(input logic w, input logic [7:0] a, input logic [7:0] d);
		logic [7:0] q;
		logic       k;
		logic [7:0] fl;
		seed = nx(seed);
		fl = a == 8'h07 ? {1'b0, oc, ot, 5'h0} : 8'h00;
		u_aafv_host.xfer(w, a, d, int'(seed[1:0]), q, k);
		chk("ack", 32'h1, {31'h0, k});
		if (w && a >= 8'h02 && a <= 8'h07) mdl[a] = d & MSK[a];
		if (!w) chk("read data", (a >= 8'h02 && a <= 8'h07) ? {24'h0, mdl[a] | fl} : 32'h0, {24'h0, q});
	endtask
	task automatic outs();
		logic [5:0] sl;
		@(posedge mclk_in);
		#2;
		sl = mdl[3][3:2] == 2'b01 ? 6'd24 : (mdl[3][3:2] == 2'b10 ? 6'd16 : 6'd32);
		chk("config outputs", {mdl[2][6:2], ard ? det : mdl[2][1:0], mdl[3][7], mdl[3][6] && mdl[2][4:2] != 3'b000,
			mdl[3][5:4], sl, mdl[3][1], mdl[4][3:0], mdl[5], mdl[6][5:4]},
			{fmt, frm, rate, intc, pul, inv, ord, slot, edg, map, att, gain});
		chk("mute", {31'h0, mdl[6][0] | (mdl[5] == 8'hFF) | am}, {31'h0, mute});
	endtask
	// n zero samples back to back, then one nonzero if asked
	task automatic run(input int n, input logic nz);
		for (int i = 0; i < n + nz; i++) begin
			@(posedge mclk_in);
			#2;
			s_stb = 1'b1;
			s_zero = i < n;
		end
		@(posedge mclk_in);
		#2;
		s_stb = 1'b0;
		if (n >= ZR && !mdl[6][7]) am = 1'b1;
		if (nz) am = 1'b0;
		repeat (2) @(posedge mclk_in);
		outs();
	endtask
	// hold faults a while and count recovery pulses; 99 means unbounded
	task automatic flt(input logic [7:0] v, input logic o, input logic t, input int e);
		xf(1'b1, 8'h07, v);
		npl = 0;
		oc = o;
		ot = t;
		repeat (60) @(posedge mclk_in);
		xf(1'b0, 8'h07, 8'h00);
		if (v[4]) xf(1'b1, 8'h07, v);
		repeat (4) @(posedge mclk_in);
		#2;
		chk("recovery pulses", e == 99 ? 32'h1 : e, e == 99 ? {31'h0, npl > 7} : npl);
		oc = 1'b0;
		ot = 1'b0;
		repeat (10) @(posedge mclk_in);
	endtask
	task automatic conclude();
		$display("checks %0d mismatches %0d", total_checks, n_fail);
		if (n_fail == 0 && total_checks > 0) $display("Test passed");
		else $display("Test failed");
		$finish;
	endtask
	initial begin
		mclk_in = 1'b0;
		forever #25 mclk_in = ~mclk_in;
	end
	// pulse counter and hang guard
	always @(posedge mclk_in) begin
		cyc++;
		if (pls === 1'b1) npl++;
		if (cyc > 5000) begin
			n_fail++;
			conclude();
		end
	end
	initial begin
		{rst_b_in, ard, det, s_stb, s_zero, oc, ot, am} = '0;
		{n_fail, total_checks, npl, cyc} = '0;
		seed = 32'h8FC01781;
		mdl = '{`AAFV_RST_FMT_RATE, `AAFV_RST_CLK_OPT, `AAFV_RST_CH_MAP, `AAFV_RST_ATTEN, `AAFV_RST_GAIN_MUTE, `AAFV_RST_FAULT};
		repeat (5) @(posedge mclk_in);
		#2;
		rst_b_in = 1'b1;
		for (int a = 1; a <= 8; a++) xf(1'b0, a[7:0], 8'h00);
		outs();
		xf(1'b1, 8'h02, 8'hF1);
		xf(1'b1, 8'h03, 8'hFB);
		xf(1'b1, 8'h04, 8'hFF);
		xf(1'b1, 8'h06, 8'hCF);
		xf(1'b1, 8'h08, 8'hFF);
		for (int a = 1; a <= 8; a++) xf(1'b0, a[7:0], 8'h00);
		outs();
		$display("reset and access kinds done");
		for (int f = 0; f < 24; f++) begin
			xf(1'b1, 8'h02, {1'b0, f[1:0], 3'(f / 4), 2'b00});
			outs();
		end
		for (int k = 0; k < 6; k++) begin
			seed = nx(seed);
			xf(1'b1, 8'h03, {seed[7:4], 2'(k % 3), seed[1:0]});
			outs();
		end
		for (int g = 0; g < 4; g++) begin
			xf(1'b1, 8'h06, {2'b11, 2'(g), 3'b111, 1'(g)});
			outs();
		end
		$display("format, clock and gain done");
		xf(1'b1, 8'h02, 8'h12);
		for (int k = 0; k < 6; k++) begin
			seed = nx(seed);
			xf(1'b1, 8'h05, k == 5 ? 8'hFF : seed[7:0]);
			xf(1'b1, 8'h04, seed[15:8]);
			outs();
		end
		xf(1'b1, 8'h05, 8'h40);
		ard = 1'b1;
		for (int d = 0; d < 3; d++) begin
			det = 2'(d);
			@(posedge mclk_in);
			outs();
		end
		ard = 1'b0;
		outs();
		$display("volume, map and rate done");
		xf(1'b1, 8'h06, 8'h00);
		run(ZR - 1, 1'b1);
		run(ZR, 1'b0);
		run(0, 1'b1);
		xf(1'b1, 8'h06, 8'h80);
		run(ZR, 1'b0);
		$display("automute done");
		flt(8'h00, 1'b1, 1'b0, 1);
		flt(8'h04, 1'b0, 1'b1, 3);
		flt(8'h08, 1'b1, 1'b1, 7);
		flt(8'h0C, 1'b1, 1'b0, 99);
		flt(8'h01, 1'b1, 1'b0, 0);
		flt(8'h06, 1'b1, 1'b0, 3);
		flt(8'h02, 1'b0, 1'b1, 0);
		flt(8'h1F, 1'b1, 1'b0, 1);
		flt(8'h7F, 1'b0, 1'b0, 0);
		$display("fault recovery done");
		conclude();
	end
endmodule
`default_nettype wire
